// File: hdl/hpp_map.svh
// host parallel port constants: addresses, field positions, reset values, timing counts
`ifndef HPP_MAP_SVH
`define HPP_MAP_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define HPP_CLK_PERIOD_PS      40000
// host strobe minimum assertion, 1.5 periods, in picoseconds
`define HPP_STROBE_ASSERT_PS   60000
// host strobe minimum gap after last data register, 2.5 periods
`define HPP_LONG_GAP_PS        100000
// host strobe minimum gap between plain accesses, 1 period
`define HPP_SHORT_GAP_PS       40000
// least time from handshake release to request re-assert, 4 periods
`define HPP_REQ_REARM_PS       160000
// host end: cycles the strobe is held and released (rounded up)
`define HPP_STROBE_ASSERT_CYC  ((`HPP_STROBE_ASSERT_PS + `HPP_CLK_PERIOD_PS - 1) / `HPP_CLK_PERIOD_PS)
`define HPP_LONG_GAP_CYC       ((`HPP_LONG_GAP_PS + `HPP_CLK_PERIOD_PS - 1) / `HPP_CLK_PERIOD_PS)
`define HPP_SHORT_GAP_CYC      ((`HPP_SHORT_GAP_PS + `HPP_CLK_PERIOD_PS - 1) / `HPP_CLK_PERIOD_PS)
`define HPP_REQ_REARM_CYC      ((`HPP_REQ_REARM_PS + `HPP_CLK_PERIOD_PS - 1) / `HPP_CLK_PERIOD_PS)

// ----------------------------------------------------------------------
// host addresses
// ----------------------------------------------------------------------
`define HPP_ADDR_ICR           4'h0
`define HPP_ADDR_CVR           4'h1
`define HPP_ADDR_ISR           4'h2
`define HPP_ADDR_WORD0         4'h4
`define HPP_ADDR_LAST          4'h7

// ----------------------------------------------------------------------
// interface control register fields (bit positions)
// ----------------------------------------------------------------------
`define HPP_ICR_DUAL_STROBE    0
`define HPP_ICR_DOUBLE_REQ     1
`define HPP_ICR_ENDIAN         2
`define HPP_ICR_DMA_SEL        3
`define HPP_ICR_DMA_EN         4
`define HPP_ICR_RESET_VAL      16'h0000

// status register fields
`define HPP_ISR_RX_FULL        0
`define HPP_ISR_TX_EMPTY       1

// ----------------------------------------------------------------------
// pin polarity selection bit positions
// ----------------------------------------------------------------------
`define HPP_POL_RD             0
`define HPP_POL_WR             1
`define HPP_POL_DS             2
`define HPP_POL_CS             3
`define HPP_POL_ACK            4
`define HPP_POL_REQ            5
`define HPP_POL_RRQ            6
`define HPP_POL_TRQ            7
`define HPP_POL_RESET_VAL      8'h00

`endif

// File: hdl/hpp_pkg.sv
// host parallel port shared types
package hpp_pkg;
    typedef enum logic [1:0] {
        HPP_H_IDLE   = 2'b00,
        HPP_H_STROBE = 2'b01,
        HPP_H_GAP    = 2'b10
    } hpp_host_state_t;
endpackage : hpp_pkg

// File: hdl/hpp_link_if.sv
// host parallel port pin bundle between host end and device end
`timescale 1ns/1ps
interface hpp_link_if;
    logic        host_chip_select;
    logic        host_read_strobe;
    logic        host_write_strobe;
    logic        host_shared_strobe;
    logic        host_read_write_line;
    logic        host_dma_acknowledge;
    logic [3:0]  host_address_lines;
    logic [15:0] host_data_out;
    logic [15:0] dev_data_out;
    logic        dev_data_oe;
    logic        host_request_pin;
    logic        host_receive_request_pin;
    logic        host_transmit_request_pin;
    logic [15:0] data_wire;

    assign data_wire = dev_data_oe ? dev_data_out : host_data_out;

    modport host (
        output host_chip_select, host_read_strobe, host_write_strobe, host_shared_strobe,
        output host_read_write_line, host_dma_acknowledge, host_address_lines, host_data_out,
        input  dev_data_out, dev_data_oe, host_request_pin, host_receive_request_pin,
        input  host_transmit_request_pin
    );
    modport device (
        input  host_chip_select, host_read_strobe, host_write_strobe, host_shared_strobe,
        input  host_read_write_line, host_dma_acknowledge, host_address_lines, host_data_out,
        input  data_wire,
        output dev_data_out, dev_data_oe, host_request_pin, host_receive_request_pin,
        output host_transmit_request_pin
    );
endinterface : hpp_link_if

// File: hdl/hpp_sync3.sv
// three-stage pin synchroniser with second/third agreement
`timescale 1ns/1ps
module hpp_sync3 (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic pin_in,
    output logic      level_out
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic lvl_ff;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lvl_ff <= 1'b0;
        end else if (s2_ff == s3_ff) begin
            lvl_ff <= s2_ff;
        end
    end

    assign level_out = lvl_ff;
endmodule : hpp_sync3

// File: hdl/hpp_device.sv
// host parallel port, device end
// ----------------------------------------------------------------------
// Overview of operation
// R01: every control pin polarity software selectable; the code gives the read/write line no polarity selection
// R02: reads use read strobe or shared strobe
// R03: writes use write strobe or shared strobe
// R04: last data register sits at address 7
// R05: endian bit picks word 0 or 3
// R06: single or double host request modes
// R07: receive request drops only when output empty
// R08: transmit request drops only when input full
// R09: request drops within 3.5 periods after read
// R10: request drops within 2.5 periods after write
// R11: config bit picks acknowledge or strobe reference
// R12: wait 4 periods before request re-asserts
// R13: request drops within 3.5 periods of assert
// R14: host holds read strobe 1.5, gap 1
// R15: host gaps 2.5 after last or control reads
// R16: long gap when reading receive after last
// R17: host write strobe 1.5, gap 2.5 after writes
// R18: read data valid within 2 periods, released after
// R19: read data valid within 1 period of select
// R20: host pins synchronised into processor clock domain
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`include "hpp_map.svh"
module hpp_device
    import hpp_pkg::*;
#(
    parameter int DEPTH = 8
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    hpp_link_if.device       link,
    input  wire logic [7:0]  pin_polarity,
    input  wire logic        out_push,
    input  wire logic [15:0] out_data,
    output logic             out_full,
    input  wire logic        in_pop,
    output logic [15:0]      in_data,
    output logic             in_empty,
    output logic [15:0]      control_word
);
    localparam int AW = $clog2(DEPTH);

    // ------------------------------------------------------------------
    // pin polarity and synchronisation
    // ------------------------------------------------------------------
    logic cs_s, rd_s, wr_s, ds_s, rw_s, ack_s;
    logic [3:0] addr_s;

    hpp_sync3 u_cs  (.clock(clock), .reset_n(reset_n), .pin_in(link.host_chip_select ^
        ~pin_polarity[`HPP_POL_CS]), .level_out(cs_s));  // [R01] [R20]
    hpp_sync3 u_rd  (.clock(clock), .reset_n(reset_n), .pin_in(link.host_read_strobe ^
        ~pin_polarity[`HPP_POL_RD]), .level_out(rd_s));  // [R01] [R20]
    hpp_sync3 u_wr  (.clock(clock), .reset_n(reset_n), .pin_in(link.host_write_strobe ^
        ~pin_polarity[`HPP_POL_WR]), .level_out(wr_s));  // [R01] [R20]
    hpp_sync3 u_ds  (.clock(clock), .reset_n(reset_n), .pin_in(link.host_shared_strobe ^
        ~pin_polarity[`HPP_POL_DS]), .level_out(ds_s));  // [R01] [R20]
    hpp_sync3 u_ack (.clock(clock), .reset_n(reset_n), .pin_in(link.host_dma_acknowledge ^
        ~pin_polarity[`HPP_POL_ACK]), .level_out(ack_s)); // [R01] [R20]
    hpp_sync3 u_rw  (.clock(clock), .reset_n(reset_n), .pin_in(link.host_read_write_line),
        .level_out(rw_s));                                // [R20]

    genvar ga;
    generate
        for (ga = 0; ga < 4; ga++) begin : g_addr
            hpp_sync3 u_a (.clock(clock), .reset_n(reset_n),
                .pin_in(link.host_address_lines[ga]), .level_out(addr_s[ga])); // [R20]
        end
    endgenerate

    // ------------------------------------------------------------------
    // strobe decode
    // ------------------------------------------------------------------
    logic [15:0] icr_ff;
    logic        dual, dbl_req, endian, dma_sel, dma_en;
    logic        rd_act, wr_act, acc_act, acc_prev_ff;
    logic        rd_prev_ff, wr_prev_ff;
    logic [3:0]  addr_lat_ff;
    logic [1:0]  word_idx;
    logic        last_hit;

    assign dual    = icr_ff[`HPP_ICR_DUAL_STROBE];
    assign dbl_req = icr_ff[`HPP_ICR_DOUBLE_REQ];
    assign endian  = icr_ff[`HPP_ICR_ENDIAN];
    assign dma_sel = icr_ff[`HPP_ICR_DMA_SEL];
    assign dma_en  = icr_ff[`HPP_ICR_DMA_EN];
    assign control_word = icr_ff;

    assign rd_act  = dual ? (rd_s & (cs_s | ack_s)) : (ds_s & rw_s & (cs_s | ack_s)); // [R02]
    assign wr_act  = dual ? (wr_s & (cs_s | ack_s)) : (ds_s & ~rw_s & (cs_s | ack_s)); // [R03]
    assign acc_act = rd_act | wr_act;

    // data words at 4..7; endian picks which word sits at address 7
    assign word_idx = endian ? 2'(addr_lat_ff[1:0]) : 2'(2'd3 - addr_lat_ff[1:0]); // [R05]
    assign last_hit = ack_s | (addr_lat_ff == `HPP_ADDR_LAST);                   // [R04]

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_prev_ff  <= 1'b0;
            wr_prev_ff  <= 1'b0;
            acc_prev_ff <= 1'b0;
            addr_lat_ff <= 4'h0;
        end else begin
            rd_prev_ff  <= rd_act;
            wr_prev_ff  <= wr_act;
            acc_prev_ff <= acc_act;
            if (acc_act && !acc_prev_ff) begin
                addr_lat_ff <= ack_s ? `HPP_ADDR_LAST : addr_s;
            end
        end
    end

    logic rd_fall, wr_fall, rd_rise, wr_rise;
    assign rd_rise = rd_act & ~rd_prev_ff;
    assign wr_rise = wr_act & ~wr_prev_ff;
    assign rd_fall = ~rd_act & rd_prev_ff;
    assign wr_fall = ~wr_act & wr_prev_ff;

    // ------------------------------------------------------------------
    // data word staging and fifos
    // ------------------------------------------------------------------
    logic [15:0] tx_word_ff [4];
    logic [15:0] rx_word_ff [4];
    logic [15:0] obuf_ff [DEPTH];
    logic [15:0] ibuf_ff [DEPTH];
    logic [AW:0] ocnt_ff, icnt_ff;
    logic [AW-1:0] ord_ff, owr_ff, ird_ff, iwr_ff;
    logic        opop, ipush;

    assign out_full = (ocnt_ff == (AW+1)'(DEPTH));
    assign in_empty = (icnt_ff == '0);
    assign in_data  = ibuf_ff[ird_ff];
    // a completed last-word read drains one output entry, a completed last-word write fills one input entry
    assign opop  = rd_fall & (addr_lat_ff == `HPP_ADDR_LAST) & (ocnt_ff != '0);
    assign ipush = wr_fall & last_hit & (icnt_ff != (AW+1)'(DEPTH));

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ocnt_ff <= '0;
            ord_ff  <= '0;
            owr_ff  <= '0;
        end else begin
            if (out_push && !out_full) begin
                obuf_ff[owr_ff] <= out_data;
                owr_ff <= owr_ff + 1'b1;
            end
            if (opop) begin
                ord_ff <= ord_ff + 1'b1;
            end
            ocnt_ff <= ocnt_ff + (AW+1)'(out_push && !out_full) - (AW+1)'(opop);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            icnt_ff <= '0;
            ird_ff  <= '0;
            iwr_ff  <= '0;
        end else begin
            if (ipush) begin
                // little endian: word 0 is the word whose write ends now
                ibuf_ff[iwr_ff] <= (word_idx == 2'd0) ? link.data_wire : rx_word_ff[0]; // [R05]
                iwr_ff <= iwr_ff + 1'b1;
            end
            if (in_pop && !in_empty) begin
                ird_ff <= ird_ff + 1'b1;
            end
            icnt_ff <= icnt_ff + (AW+1)'(ipush) - (AW+1)'(in_pop && !in_empty);
        end
    end

    always_ff @(posedge clock) begin
        for (int i = 0; i < 4; i++) begin
            tx_word_ff[i] <= obuf_ff[ord_ff];
        end
    end

    // ------------------------------------------------------------------
    // host writes: control register and receive words
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            icr_ff <= `HPP_ICR_RESET_VAL;
            for (int i = 0; i < 4; i++) rx_word_ff[i] <= 16'h0000;
        end else if (wr_fall) begin
            if (addr_lat_ff == `HPP_ADDR_ICR) begin
                icr_ff <= link.data_wire;
            end else if (addr_lat_ff[3:2] == 2'b01) begin
                rx_word_ff[word_idx] <= link.data_wire;
            end
        end
    end

    // ------------------------------------------------------------------
    // read data: driven from strobe assertion, released on deassertion
    // ------------------------------------------------------------------
    logic [15:0] rdata_ff;
    logic        oe_ff;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= 16'h0000;
            oe_ff    <= 1'b0;
        end else begin
            oe_ff <= rd_act;                                   // [R18]
            if (cs_s || ack_s) begin                           // [R19]
                unique case (ack_s ? `HPP_ADDR_LAST : addr_s)
                    `HPP_ADDR_ICR: rdata_ff <= icr_ff;
                    `HPP_ADDR_ISR: rdata_ff <= {14'h0000, ocnt_ff == '0, ocnt_ff != '0};
                    4'h4, 4'h5, 4'h6, 4'h7: rdata_ff <= tx_word_ff[0];
                    default: rdata_ff <= 16'h0000;
                endcase
            end
        end
    end

    assign link.dev_data_out = rdata_ff;
    assign link.dev_data_oe  = oe_ff;                          // [R18]

    // ------------------------------------------------------------------
    // host request generation
    // ------------------------------------------------------------------
    logic       hs_act, hs_prev_ff, req_ff, rrq_ff, trq_ff;
    logic [2:0] rearm_ff;
    logic       want;

    assign hs_act = dma_sel ? acc_act : ack_s;                 // [R11]
    assign want   = (ocnt_ff != '0) | (icnt_ff != (AW+1)'(DEPTH));

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            hs_prev_ff <= 1'b0;
            rearm_ff   <= 3'h0;
            req_ff     <= 1'b0;
        end else begin
            hs_prev_ff <= hs_act;
            if (dma_en && hs_act && !hs_prev_ff) begin
                req_ff   <= 1'b0;                               // [R13]
                rearm_ff <= 3'(`HPP_REQ_REARM_CYC);
            end else if ((rd_fall || wr_fall) && addr_lat_ff == `HPP_ADDR_LAST) begin
                req_ff   <= 1'b0;                               // [R09] [R10]
                rearm_ff <= 3'(`HPP_REQ_REARM_CYC);
            end else if (hs_act || rearm_ff != 3'h0) begin
                if (!hs_act) rearm_ff <= rearm_ff - 3'h1;       // [R12]
            end else begin
                req_ff <= want;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rrq_ff <= 1'b0;
            trq_ff <= 1'b0;
        end else begin
            rrq_ff <= (ocnt_ff != '0);                          // [R07]
            trq_ff <= (icnt_ff != (AW+1)'(DEPTH));              // [R08]
        end
    end

    assign link.host_request_pin = (~dbl_req & req_ff)
        ^ ~pin_polarity[`HPP_POL_REQ];                          // [R06] [R01]
    assign link.host_receive_request_pin = (dbl_req & rrq_ff)
        ^ ~pin_polarity[`HPP_POL_RRQ];                          // [R06] [R01]
    assign link.host_transmit_request_pin = (dbl_req & trq_ff)
        ^ ~pin_polarity[`HPP_POL_TRQ];                          // [R06] [R01]
endmodule : hpp_device

// File: hdl/hpp_host.sv
// host parallel port, host end
`timescale 1ns/1ps
`include "hpp_map.svh"
module hpp_host
    import hpp_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    hpp_link_if.host         link,
    input  wire logic        dual_strobe,
    input  wire logic [7:0]  pin_polarity,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_write,
    input  wire logic [3:0]  cmd_addr,
    input  wire logic [15:0] cmd_wdata,
    output logic [15:0]      rsp_data,
    output logic             rsp_valid
);
    // ------------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------------
    hpp_host_state_t state_ff;
    logic [2:0]  cnt_ff;
    logic        wr_ff, long_ff;
    logic [3:0]  addr_ff;
    logic [15:0] wdata_ff, rdata_ff;
    logic        rvld_ff;

    assign cmd_ready = (state_ff == HPP_H_IDLE);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= HPP_H_IDLE;
            cnt_ff   <= 3'h0;
            wr_ff    <= 1'b0;
            long_ff  <= 1'b0;
            addr_ff  <= 4'h0;
            wdata_ff <= 16'h0000;
            rdata_ff <= 16'h0000;
            rvld_ff  <= 1'b0;
        end else begin
            rvld_ff <= 1'b0;
            unique case (state_ff)
                HPP_H_IDLE: begin
                    if (cmd_valid) begin
                        state_ff <= HPP_H_STROBE;
                        wr_ff    <= cmd_write;
                        addr_ff  <= cmd_addr;
                        wdata_ff <= cmd_wdata;
                        // held past the far end pin synchroniser so read data has settled
                        cnt_ff   <= 3'(`HPP_STROBE_ASSERT_CYC + 4);   // [R14] [R17]
                        long_ff  <= cmd_write || cmd_addr == `HPP_ADDR_LAST
                                    || cmd_addr[3:2] == 2'b00;         // [R15] [R16] [R17]
                    end
                end
                HPP_H_STROBE: begin
                    if (cnt_ff == 3'h1) begin
                        state_ff <= HPP_H_GAP;
                        if (!wr_ff) begin
                            rdata_ff <= link.dev_data_out;
                            rvld_ff  <= 1'b1;
                        end
                        cnt_ff <= long_ff ? 3'(`HPP_LONG_GAP_CYC + 1)
                                          : 3'(`HPP_SHORT_GAP_CYC + 1); // [R14] [R15]
                    end else begin
                        cnt_ff <= cnt_ff - 3'h1;
                    end
                end
                HPP_H_GAP: begin
                    if (cnt_ff == 3'h1) begin
                        state_ff <= HPP_H_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 3'h1;
                    end
                end
                default: state_ff <= HPP_H_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pins
    // ------------------------------------------------------------------
    logic strobe;
    assign strobe = (state_ff == HPP_H_STROBE);

    assign link.host_chip_select     = (state_ff != HPP_H_IDLE) ^ ~pin_polarity[`HPP_POL_CS];
    assign link.host_read_strobe     = (dual_strobe & strobe & ~wr_ff)
                                       ^ ~pin_polarity[`HPP_POL_RD];   // [R02]
    assign link.host_write_strobe    = (dual_strobe & strobe & wr_ff)
                                       ^ ~pin_polarity[`HPP_POL_WR];   // [R03]
    assign link.host_shared_strobe   = (~dual_strobe & strobe)
                                       ^ ~pin_polarity[`HPP_POL_DS];   // [R02] [R03]
    assign link.host_read_write_line = ~wr_ff;
    assign link.host_dma_acknowledge = ~pin_polarity[`HPP_POL_ACK];
    assign link.host_address_lines   = addr_ff;
    assign link.host_data_out        = wdata_ff;
    assign rsp_data  = rdata_ff;
    assign rsp_valid = rvld_ff;
endmodule : hpp_host

// File: bench/hpp_link_props.sv
// pin-level checks on the link between host end and device end
`timescale 1ns/1ps
module hpp_link_props (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic [7:0] pin_polarity,
    input wire logic       dual_strobe,
    input wire logic       host_chip_select,
    input wire logic       host_read_strobe,
    input wire logic       host_write_strobe,
    input wire logic       host_shared_strobe,
    input wire logic       host_read_write_line,
    input wire logic       dev_data_oe
);
    logic rd_act, wr_act, ds_act, cs_act, rd_any, any;
    // active levels after polarity selection
    assign rd_act = host_read_strobe == pin_polarity[0];
    assign wr_act = host_write_strobe == pin_polarity[1];
    assign ds_act = host_shared_strobe == pin_polarity[2];
    assign cs_act = host_chip_select == pin_polarity[3];
    assign rd_any = dual_strobe ? rd_act : ds_act & host_read_write_line;
    assign any    = dual_strobe ? rd_act | wr_act : ds_act;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_strobe_needs_select: assert property (any |-> cs_act)
        else $error("strobe active without chip select");
    a_dual_no_shared: assert property (dual_strobe |-> !ds_act)
        else $error("shared strobe used in dual mode");
    a_single_no_dedicated: assert property (!dual_strobe |-> !rd_act && !wr_act)
        else $error("dedicated strobe used in single mode");
    a_strobe_min_width: assert property ($rose(any) |=> any)
        else $error("strobe too short");
    a_strobe_min_gap: assert property ($fell(any) |-> !any [*2])
        else $error("strobe gap too short");
    a_read_drives_bus: assert property ($rose(rd_any) |-> ##[1:8] dev_data_oe)
        else $error("read data not driven");
    a_bus_released: assert property (!rd_any [*8] |-> !dev_data_oe)
        else $error("data bus not released");
    a_read_synced: assert property ($rose(rd_any) |-> !$rose(dev_data_oe) ##1 !$rose(dev_data_oe))
        else $error("bus driven before strobe synchronised");
endmodule : hpp_link_props

// File: bench/host_parallel_port_timing_tb.sv
// self-checking bench joining host end and device end
`timescale 1ns/1ps
module host_parallel_port_timing_tb;
    logic             clock, reset_n, dual_strobe, cmd_valid, cmd_write, out_push, in_pop;
    logic [7:0]       pin_polarity;
    logic [3:0]       cmd_addr;
    logic [15:0]      cmd_wdata, out_data, exp_v;
    wire logic        cmd_ready, rsp_valid, out_full, in_empty;
    wire logic [15:0] rsp_data, in_data, control_word;
    logic [15:0]      rsp_q[$], in_q[$];
    int               n_mismatch, tests_run, cycles, seed;

    hpp_link_if link ();
    hpp_host u_hpp_host (.clock(clock), .reset_n(reset_n), .link(link.host),
        .dual_strobe(dual_strobe), .pin_polarity(pin_polarity), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .rsp_data(rsp_data), .rsp_valid(rsp_valid));
    hpp_device #(.DEPTH(8)) u_hpp_device (.clock(clock), .reset_n(reset_n),
        .link(link.device), .pin_polarity(pin_polarity), .out_push(out_push),
        .out_data(out_data), .out_full(out_full), .in_pop(in_pop), .in_data(in_data),
        .in_empty(in_empty), .control_word(control_word));
    hpp_link_props u_hpp_link_props (.clock(clock), .reset_n(reset_n),
        .pin_polarity(pin_polarity), .dual_strobe(dual_strobe),
        .host_chip_select(link.host_chip_select), .host_read_strobe(link.host_read_strobe),
        .host_write_strobe(link.host_write_strobe),
        .host_shared_strobe(link.host_shared_strobe),
        .host_read_write_line(link.host_read_write_line), .dev_data_oe(link.dev_data_oe));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic xfer(input logic wr, input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        #1 cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr = a;
        cmd_wdata = d;
        do @(negedge clock); while (cmd_ready !== 1'b1);
        @(posedge clock);
        #1 cmd_valid = 1'b0;
    endtask : xfer

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize

    // ----------------------------------------------------------------------
    // result watchers and timeout
    // ----------------------------------------------------------------------
    always @(posedge clock) begin
        if (rsp_valid === 1'b1 && rsp_q.size() > 0) check("rsp_data", rsp_q.pop_front(), rsp_data);
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end

    always @(posedge clock) begin
        #1;
        if (in_pop) in_pop = 1'b0;
        else if (in_empty === 1'b0 && in_q.size() > 0) begin
            check("in_data", in_q.pop_front(), in_data);
            in_pop = 1'b1;
        end
    end

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        seed = 43;
        {reset_n, dual_strobe, cmd_valid, cmd_write, out_push, in_pop} = '0;
        {pin_polarity, cmd_addr, cmd_wdata, out_data} = '0;
        for (int cfg = 0; cfg < 4; cfg++) begin
            pin_polarity = cfg[0] ? 8'hff : 8'h00;
            dual_strobe = 1'b0;
            reset_n = 1'b0;
            repeat (10) @(posedge clock);
            #1 reset_n = 1'b1;
            exp_v = {11'($random(seed)), 2'b00, cfg[0], 1'b0, cfg[1]};
            xfer(1'b1, 4'h0, exp_v);
            for (int i = 0; i < 40 && control_word !== exp_v; i++) @(posedge clock);
            check("control_word", exp_v, control_word);
            #1 dual_strobe = cfg[1];
            repeat (3) begin
                exp_v = 16'($random(seed));
                @(posedge clock);
                #1 out_push = 1'b1;
                out_data = exp_v;
                @(posedge clock);
                #1 out_push = 1'b0;
                rsp_q.push_back(exp_v);
                xfer(1'b0, 4'h7, 16'h0);
                for (int a = 4; a < 8; a++) begin
                    exp_v = 16'($random(seed));
                    if (a == (cfg[0] ? 4 : 7)) in_q.push_back(exp_v);
                    xfer(1'b1, a[3:0], exp_v);
                end
            end
            for (int i = 0; i < 200 && rsp_q.size() + in_q.size() > 0; i++) @(posedge clock);
            check("pending", 16'h0, 16'(rsp_q.size() + in_q.size()));
            repeat (8) @(posedge clock);
            exp_v = {13'h0, link.host_request_pin, link.host_receive_request_pin,
                     link.host_transmit_request_pin};
            check("request_pins", {13'h0, cfg[0], ~cfg[0], ~cfg[0]}, exp_v);
            $display("test cfg %0d done", cfg);
        end
        summarize();
    end
endmodule : host_parallel_port_timing_tb
